// [stgt_pkg.sv]
`default_nettype none
// ==========================================
// Register map and field layout
package stgt_pkg;
  localparam logic [7:0]  OFS_SAFE_CFG    = 8'h1b;  // Safe config offset
  localparam logic [7:0]  OFS_MONITOR     = 8'h1c;  // Timing monitor offset
  localparam logic [15:0] RST_SAFE_CFG    = 16'h2000;
  localparam logic [15:0] RST_MONITOR     = 16'hff01;
  localparam int          DLY_MSB         = 15;
  localparam int          DLY_LSB         = 8;
  localparam int          PLAT_MSB        = 7;
  localparam int          PLAT_LSB        = 4;
  localparam int          ARMED_BIT       = 7;
  localparam int          LMI_BIT         = 1;
  localparam int          PAR_BIT         = 0;
  localparam logic [7:0]  DLY_MIN_USED    = 8'h0a;  // Least delay when enabled
  localparam logic [7:0]  CNT_SAT         = 8'hff;
  localparam int          CNT_MSB         = 15;     // Timing count field top
  localparam int          CNT_LSB         = 8;      // Timing count field bottom
  localparam logic [15:0] RST_RD_WORD     = 16'h0001;  // Read word before first select
endpackage : stgt_pkg
`default_nettype wire

// [stgt_regs.sv]
// What this block does
// - Bits 15:8 of the safe config register hold the two-level delay in oscillator cycles.
// - A zero delay field switches the safe two-level delay off.
// - Bits 7:4 select the safe plateau voltage, coded like the regular plateau field.
// - Bit 1 of each read word reports whether the last message was discarded.
// - Bit 0 of each read word is odd parity over the word.
// - Bits 15:8 of the monitor register hold the turn-off timing count.
// - The count is cleared when a measurement begins.
// - Bit 7 of the monitor register reads 1 while capture is armed.
// - The armed flag clears when the measurement ends.
// - A new request while armed clears the flag and disarms.
`timescale 1ns/1ps
`default_nettype none
module stgt_regs (
  input  wire logic        clk_i,           // Secondary oscillator clock
  input  wire logic        reset_n_i,       // Async reset, active low
  input  wire logic        wr_en_i,         // Register write strobe
  input  wire logic [7:0]  addr_i,          // Register offset
  input  wire logic [15:0] wr_data_i,       // Write data
  input  wire logic        msg_invalid_i,   // Pulse: message discarded
  input  wire logic        msg_valid_i,     // Pulse: message processed
  input  wire logic        meas_start_i,    // Pulse: measurement request
  input  wire logic        meas_end_i,      // Pulse: measurement ends
  output logic      [15:0] rd_data_o,       // Registered read word
  output logic      [7:0]  safe_delay_o,    // Safe delay value
  output logic             safe_tlto_en_o,  // Two-level delay enabled
  output logic      [3:0]  safe_plateau_o,  // Safe plateau voltage code
  output logic             armed_o          // Capture armed
);
  // ==========================================
  // State registers and their next values
  logic [7:0]  dly_r;         // Safe delay value field
  logic [7:0]  dly_nxt;       // Next safe delay value
  logic [3:0]  plat_r;        // Safe plateau voltage code
  logic [3:0]  plat_nxt;      // Next plateau code
  logic        en_r;          // Two-level delay in use
  logic        en_nxt;        // Next enable
  logic [7:0]  cnt_r;         // Turn-off timing count
  logic [7:0]  cnt_nxt;       // Next timing count
  logic        arm_r;         // Capture armed flag
  logic        arm_nxt;       // Next armed flag
  logic        lmi_r;         // Last message invalid
  logic        lmi_nxt;       // Next message status
  logic [15:0] rd_r;          // Registered read word
  logic [15:0] rd_nxt;        // Next read word

  // Decoded events, all on this clock
  logic        cfg_wr;        // Write hits safe config
  logic        start_arm;     // Request while idle
  logic        start_disarm;  // Request while armed
  logic        cnt_run;       // Count may advance
  logic [15:0] word;          // Read word being built

  // ==========================================
  // Safe turn-off configuration
  // Only the safe config word takes writes; others are dropped
  assign cfg_wr = wr_en_i && (addr_i == stgt_pkg::OFS_SAFE_CFG);

  // Next delay, plateau and delay enable
  always_comb begin
    dly_nxt  = dly_r;
    plat_nxt = plat_r;
    if (cfg_wr) begin
      dly_nxt  = wr_data_i[stgt_pkg::DLY_MSB:stgt_pkg::DLY_LSB];
      plat_nxt = wr_data_i[stgt_pkg::PLAT_MSB:stgt_pkg::PLAT_LSB];
    end
    // Enable follows the value being stored, so both change together
    en_nxt = (dly_nxt != 8'h00);
  end

  // Config registers, loaded with the reset word
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dly_r  <= stgt_pkg::RST_SAFE_CFG[stgt_pkg::DLY_MSB:stgt_pkg::DLY_LSB];
      plat_r <= stgt_pkg::RST_SAFE_CFG[stgt_pkg::PLAT_MSB:stgt_pkg::PLAT_LSB];
      en_r   <= (stgt_pkg::RST_SAFE_CFG[stgt_pkg::DLY_MSB:stgt_pkg::DLY_LSB] != 8'h00);
    end else begin
      dly_r  <= dly_nxt;
      plat_r <= plat_nxt;
      en_r   <= en_nxt;
    end
  end

  // ==========================================
  // Message status
  // Discard beats accept when both arrive together
  always_comb begin
    lmi_nxt = lmi_r;
    if (msg_valid_i) begin
      lmi_nxt = 1'b0;
    end
    if (msg_invalid_i) begin
      lmi_nxt = 1'b1;
    end
  end

  // Message status register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lmi_r <= 1'b0;
    end else begin
      lmi_r <= lmi_nxt;
    end
  end

  // ==========================================
  // Turn-off timing capture
  // A request arms when idle and disarms when already armed
  assign start_arm    = meas_start_i && !arm_r;
  assign start_disarm = meas_start_i && arm_r;
  // Count stops at all ones so a long turn-off never looks short
  assign cnt_run      = arm_r && (cnt_r != stgt_pkg::CNT_SAT);

  // Next count and armed flag; a request beats an end in one cycle
  always_comb begin
    cnt_nxt = cnt_r;
    arm_nxt = arm_r;
    if (cnt_run) begin
      cnt_nxt = cnt_r + 8'h01;
    end
    if (meas_end_i) begin
      arm_nxt = 1'b0;
    end
    if (start_disarm) begin
      arm_nxt = 1'b0;
    end
    if (start_arm) begin
      arm_nxt = 1'b1;
      cnt_nxt = 8'h00;
    end
  end

  // Capture registers; count comes up saturated
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= stgt_pkg::RST_MONITOR[stgt_pkg::CNT_MSB:stgt_pkg::CNT_LSB];
      arm_r <= stgt_pkg::RST_MONITOR[stgt_pkg::ARMED_BIT];
    end else begin
      cnt_r <= cnt_nxt;
      arm_r <= arm_nxt;
    end
  end

  // ==========================================
  // Read word
  // Word for the selected offset; reserved bits stay zero
  always_comb begin
    word = 16'h0000;
    case (addr_i)
      stgt_pkg::OFS_SAFE_CFG: begin
        word[stgt_pkg::DLY_MSB:stgt_pkg::DLY_LSB]   = dly_r;
        word[stgt_pkg::PLAT_MSB:stgt_pkg::PLAT_LSB] = plat_r;
      end
      stgt_pkg::OFS_MONITOR: begin
        word[stgt_pkg::CNT_MSB:stgt_pkg::CNT_LSB] = cnt_r;
        word[stgt_pkg::ARMED_BIT]                 = arm_r;
      end
      default: begin
        word = 16'h0000;
      end
    endcase
    // Status and parity ride on every word, mapped or not
    word[stgt_pkg::LMI_BIT] = lmi_r;
    word[stgt_pkg::PAR_BIT] = ~(^word[15:1]);
    rd_nxt = word;
  end

  // Read word register; odd parity holds from reset on
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_r <= stgt_pkg::RST_RD_WORD;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  // ==========================================
  // Outputs, each straight from a register
  assign rd_data_o      = rd_r;
  assign safe_delay_o   = dly_r;
  assign safe_plateau_o = plat_r;
  assign safe_tlto_en_o = en_r;
  assign armed_o        = arm_r;

  // ==========================================
  // Checks
  property p_parity;
    @(posedge clk_i) disable iff (!reset_n_i) ^rd_r == 1'b1;
  endproperty
  a_parity: assert property (p_parity) else $error("even parity");
  property p_clear;
    @(posedge clk_i) disable iff (!reset_n_i) (meas_start_i && !arm_r) |=> (cnt_r == 8'h00 && arm_r);
  endproperty
  a_clear: assert property (p_clear) else $error("no clear");
  property p_disarm;
    @(posedge clk_i) disable iff (!reset_n_i) (meas_start_i && arm_r) |=> !arm_r;
  endproperty
  a_disarm: assert property (p_disarm) else $error("no disarm");
  property p_end;
    @(posedge clk_i) disable iff (!reset_n_i) (meas_end_i && !meas_start_i) |=> !arm_r;
  endproperty
  a_end: assert property (p_end) else $error("armed after end");
  property p_count;
    @(posedge clk_i) disable iff (!reset_n_i)
      (arm_r && !meas_start_i && cnt_r != 8'hff) |=> cnt_r == $past(cnt_r) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("no count");
  property p_sat;
    @(posedge clk_i) disable iff (!reset_n_i) (cnt_r == 8'hff && !meas_start_i) |=> cnt_r == 8'hff;
  endproperty
  a_sat: assert property (p_sat) else $error("wrapped");
  property p_lmi;
    @(posedge clk_i) disable iff (!reset_n_i) msg_invalid_i |=> ##1 rd_r[1];
  endproperty
  a_lmi: assert property (p_lmi) else $error("lmi lost");
  property p_rsv;
    @(posedge clk_i) disable iff (!reset_n_i) rd_r[3:2] == 2'b00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_en;
    @(posedge clk_i) disable iff (!reset_n_i)
      (wr_en_i && addr_i == 8'h1b && wr_data_i[15:8] == 8'h00) |=> !safe_tlto_en_o;
  endproperty
  a_en: assert property (p_en) else $error("zero delay enabled");

  // ==========================================
  // Further checks
  // Written delay lands one cycle later
  property p_dly_load;
    @(posedge clk_i) disable iff (!reset_n_i)
      cfg_wr |=> dly_r == $past(wr_data_i[15:8]);
  endproperty
  a_dly_load: assert property (p_dly_load) else $error("delay not loaded");
  // Written plateau code lands one cycle later
  property p_plat_load;
    @(posedge clk_i) disable iff (!reset_n_i)
      cfg_wr |=> plat_r == $past(wr_data_i[7:4]);
  endproperty
  a_plat_load: assert property (p_plat_load) else $error("plateau not loaded");
  // Config holds without a write to it
  property p_cfg_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      !cfg_wr |=> $stable(dly_r) && $stable(plat_r);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");
  // Nonzero delay keeps the two-level step on
  property p_en_on;
    @(posedge clk_i) disable iff (!reset_n_i)
      (cfg_wr && wr_data_i[15:8] != 8'h00) |=> safe_tlto_en_o;
  endproperty
  a_en_on: assert property (p_en_on) else $error("nonzero delay disabled");
  // Monitor reserved bits read as zero
  property p_mon_rsv;
    @(posedge clk_i) disable iff (!reset_n_i)
      ($past(addr_i) == stgt_pkg::OFS_MONITOR) |-> rd_r[6:2] == 5'h00;
  endproperty
  a_mon_rsv: assert property (p_mon_rsv) else $error("monitor reserved set");
  // Unmapped offsets read only status and parity
  property p_unmapped;
    @(posedge clk_i) disable iff (!reset_n_i)
      ($past(addr_i) != stgt_pkg::OFS_MONITOR && $past(addr_i) != stgt_pkg::OFS_SAFE_CFG)
      |-> rd_r[15:2] == 14'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
  // Accepted message clears the status flag
  property p_lmi_clear;
    @(posedge clk_i) disable iff (!reset_n_i)
      (msg_valid_i && !msg_invalid_i) |=> !lmi_r;
  endproperty
  a_lmi_clear: assert property (p_lmi_clear) else $error("status not cleared");
  // Count field shows the count of the cycle before
  property p_cnt_field;
    @(posedge clk_i) disable iff (!reset_n_i)
      ($past(addr_i) == stgt_pkg::OFS_MONITOR) |-> rd_r[15:8] == $past(cnt_r);
  endproperty
  a_cnt_field: assert property (p_cnt_field) else $error("count field wrong");
  // Armed bit shows the flag of the cycle before
  property p_arm_field;
    @(posedge clk_i) disable iff (!reset_n_i)
      ($past(addr_i) == stgt_pkg::OFS_MONITOR) |-> rd_r[7] == $past(arm_r);
  endproperty
  a_arm_field: assert property (p_arm_field) else $error("armed bit wrong");
  // Flag holds with no request and no end
  property p_arm_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      (!meas_start_i && !meas_end_i) |=> arm_r == $past(arm_r);
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("armed flag moved");
  // Count holds while idle
  property p_idle_count;
    @(posedge clk_i) disable iff (!reset_n_i)
      (!arm_r && !meas_start_i) |=> $stable(cnt_r);
  endproperty
  a_idle_count: assert property (p_idle_count) else $error("idle count moved");
endmodule : stgt_regs
`default_nettype wire

// [stgt_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host side register master
module stgt_host (
  input  wire logic        clk_i,          // Clock
  output logic             wr_en_o,        // Write strobe
  output logic      [7:0]  addr_o,         // Offset
  output logic      [15:0] wr_data_o,      // Write data
  output logic             msg_invalid_o,  // Discard pulse
  output logic             msg_valid_o     // Accept pulse
);
  // Idle levels
  initial begin
    {wr_en_o, addr_o, wr_data_o, msg_invalid_o, msg_valid_o} = 27'h0;
  end
  // One-cycle write; delay kept 0 or at least 0x0a, no regular delay set
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    if (d[15:8] != 8'h00 && d[15:8] < stgt_pkg::DLY_MIN_USED) d[15:8] = 8'h00;
    @(posedge clk_i);
    {wr_en_o, addr_o, wr_data_o} <= {1'b1, a, d};
    @(posedge clk_i);
    wr_en_o <= 1'b0;
  endtask : write
  // Select read word
  task automatic point(input logic [7:0] a);
    @(posedge clk_i);
    addr_o <= a;
  endtask : point
  // Message status pulse
  task automatic msg(input logic bad);
    @(posedge clk_i);
    {msg_invalid_o, msg_valid_o} <= {bad, ~bad};
    @(posedge clk_i);
    {msg_invalid_o, msg_valid_o} <= 2'b00;
  endtask : msg
endmodule : stgt_host
`default_nettype wire

// [stgt_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench top
module stgt_regs_tb;
  logic clk_i, reset_n_i, meas_start_i, meas_end_i, wr_en, m_inv, m_val, en, arm;
  logic [7:0] addr, dly;
  logic [3:0] plat;
  logic [15:0] wdat, rd_data_o, d;
  logic [31:0] lfsr;
  int fails = 0, n_checks = 0;
  stgt_host i_host (.clk_i(clk_i), .wr_en_o(wr_en), .addr_o(addr), .wr_data_o(wdat),
    .msg_invalid_o(m_inv), .msg_valid_o(m_val));
  stgt_regs i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en), .addr_i(addr),
    .wr_data_i(wdat), .msg_invalid_i(m_inv), .msg_valid_i(m_val), .meas_start_i(meas_start_i),
    .meas_end_i(meas_end_i), .rd_data_o(rd_data_o), .safe_delay_o(dly), .safe_tlto_en_o(en),
    .safe_plateau_o(plat), .armed_o(arm));
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    fails++;
    close_out();
  end
  // Odd parity word
  function automatic logic [15:0] par(input logic [15:0] w);
    return {w[15:1], ~(^w[15:1])};
  endfunction : par
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask : chk
  // Read word two edges after address
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    i_host.point(a);
    repeat (2) @(posedge clk_i);
    #1 chk("rd_data_o", e, rd_data_o & m);
  endtask : rd
  task automatic pls(input logic s);
    @(posedge clk_i) {meas_start_i, meas_end_i} <= {s, ~s};
    @(posedge clk_i) {meas_start_i, meas_end_i} <= 2'b00;
  endtask : pls
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    {meas_start_i, meas_end_i, reset_n_i} = 3'b000;
    lfsr = 32'h6b3e;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(stgt_pkg::OFS_SAFE_CFG, 16'h2000, 16'hffff);
    rd(stgt_pkg::OFS_MONITOR, 16'hff01, 16'hffff);
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      d = {(i == 0) ? 8'h00 : (lfsr[23:16] | 8'h10), lfsr[7:0]};
      i_host.write(stgt_pkg::OFS_SAFE_CFG, d);
      rd(stgt_pkg::OFS_SAFE_CFG, par({d[15:4], 4'h0}), 16'hffff);
      chk("cfg outputs", {3'b0, d[15:4], d[15:8] != 8'h00}, {3'b0, dly, plat, en});
    end
    i_host.write(stgt_pkg::OFS_MONITOR, 16'h0000);
    rd(stgt_pkg::OFS_MONITOR, 16'hff01, 16'hffff);
    i_host.msg(1'b1);
    rd(8'h05, 16'h0002, 16'hffff);
    i_host.msg(1'b0);
    rd(8'h05, 16'h0001, 16'hffff);
    pls(1'b1);
    repeat (300) @(posedge clk_i);
    rd(stgt_pkg::OFS_MONITOR, 16'hff80, 16'hffff);
    chk("armed_o", 16'h0001, {15'h0000, arm});
    pls(1'b1);
    rd(stgt_pkg::OFS_MONITOR, 16'hff01, 16'hffff);
    chk("armed_o", 16'h0000, {15'h0000, arm});
    pls(1'b1);
    rd(stgt_pkg::OFS_MONITOR, 16'h0080, 16'hf8fe);
    pls(1'b0);
    rd(stgt_pkg::OFS_MONITOR, 16'h0000, 16'h00fc);
    close_out();
  end
endmodule : stgt_regs_tb
`default_nettype wire
